/* src/mfb_pkg.sv */
/*
 Shared constants of the motion feedback block: capture edge codes,
 timer and pulse counter limits, filter length and mode bit positions.
 Assumes a single system clock and plain configuration ports.
*/
// What this block does
// R1 - One sub-module owns pins; capture after reset
// R2 - Filter needs four equal samples per edge
// R3 - Sources hold levels at least a cycle
// R4 - Two-bit edge select: rising, falling, both
// R5 - Trigger copies shared timer, sets capture flag
// R6 - Capture flags ORed, gated; software clears only
// R7 - Clear timer after capture when enabled
// R8 - Reload overflow loads reload value, else zero; code also loads zero while timer clear on capture is set
// R9 - Compare mode match sets flag, restarts zero
// R10 - Reload overflow sets flag; no reload gives zero
// R11 - Selected capture pin also reloads timer
// R12 - Pin 2 detection gated by encoder, index
// R13 - Four encoder modes: x4/x2, free/compare
// R14 - Sixteen-bit pulse counter with latched copy
// R15 - Encoder mode reuses capture register pairs
// R16 - Pins 0 and 1 become phases
// R17 - Phase lead or lag gives sense, strobe
// R18 - Free counts full range; compare uses limit
// R19 - Counter kept across mode change, disable
// R20 - Index edge sets capture flag 2
// R21 - Free mode wrap sets pulse wrap flag
// R22 - Encoder flags reuse capture flags 0, 1
// R23 - Modes 00b/10b x4, 01b/11b x2
// R24 - A leads: sense 1, increment; else decrement
// R25 - Compare up: limit to zero sets wrap
// R26 - Compare down: zero reloads limit, sets wrap
// R27 - Sense change sets reversal flag
package mfb_pkg;
   localparam int          NUM_CHAN       = 3;
   localparam int          FILTER_LEN     = 4;
   localparam logic [1:0]  EDGE_OFF       = 2'h0;
   localparam logic [1:0]  EDGE_RISE      = 2'h1;
   localparam logic [1:0]  EDGE_FALL      = 2'h2;
   localparam logic [1:0]  EDGE_BOTH      = 2'h3;
   localparam logic [1:0]  RLD_NONE       = 2'h0;
   localparam int          MODE_X2_BIT    = 0;
   localparam int          MODE_CMP_BIT   = 1;
   localparam logic [15:0] TIMER_RST      = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hffff;
   localparam logic [15:0] COUNT_RST      = 16'h0000;
endpackage : mfb_pkg

/* src/mfb_edge_if.sv */
/*
 Carrier for one filtered capture input: stable level and edge pulses.
 Assumes producer and consumer run on the same clock.
*/
`timescale 1ns/100ps
interface mfb_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : mfb_edge_if

/* src/mfb_edge_filter.sv */
/*
 Optional noise filter and edge detector for one capture pin.
 Assumes the pin is already synchronous to i_core_clk.
*/
`timescale 1ns/100ps
module mfb_edge_filter #(
   parameter int FILT_LEN = mfb_pkg::FILTER_LEN
) (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_sys_rst,
   // Pin and control
   input  wire logic i_pin,
   input  wire logic i_filter_en,
   // Filtered output
   mfb_edge_if.src   o_edge
);
   logic       smp_r;
   logic       stb_r;
   logic       stb_nxt;
   logic [1:0] cnt_r;
   logic       rise_r;
   logic       fall_r;

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         smp_r <= 1'b0;
      end else begin
         smp_r <= i_pin;
      end
   end

   // Short pulses never reach FILT_LEN equal samples
   always_comb begin
      stb_nxt = stb_r;
      if (!i_filter_en) begin
         stb_nxt = smp_r;
      end else if (smp_r != stb_r && cnt_r == 2'(FILT_LEN - 1)) begin
         stb_nxt = smp_r; // R2 R3
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_r <= 2'h0;
      end else if (!i_filter_en || smp_r == stb_r
                   || cnt_r == 2'(FILT_LEN - 1)) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1; // R2
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stb_r  <= 1'b0;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         stb_r  <= stb_nxt;
         rise_r <= stb_nxt & ~stb_r;
         fall_r <= ~stb_nxt & stb_r;
      end
   end

   assign o_edge.level = stb_r;
   assign o_edge.rise  = rise_r;
   assign o_edge.fall  = fall_r;

   chk_filter_four_samples: assert property ( // R2
      @(posedge i_core_clk) disable iff (i_sys_rst)
      ($past(i_filter_en) && i_filter_en && stb_r != $past(stb_r))
      |-> ($past(smp_r, 1) == stb_r && $past(smp_r, 2) == stb_r
           && $past(smp_r, 3) == stb_r && $past(smp_r, 4) == stb_r))
      else $error("filter changed level without four equal samples");
endmodule : mfb_edge_filter

/* src/mfb_motion_feedback.sv */
/*
 Motion feedback block: three-channel input capture on a shared timer
 with compare and reload modes, and a quadrature encoder counter that
 takes over capture pins 0 and 1. Assumes pins synchronous to the clock
 and software strobes that last one cycle.
*/
`timescale 1ns/100ps
module mfb_motion_feedback #(
   parameter int NCH = mfb_pkg::NUM_CHAN
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   // Capture pins
   input  wire logic [2:0]  i_capture_pin,
   // Capture configuration
   input  wire logic [2:0]  i_filter_enable,
   input  wire logic [5:0]  i_edge_select,
   input  wire logic [2:0]  i_capture_enable,
   input  wire logic        i_capture_irq_enable,
   input  wire logic [2:0]  i_capture_flag_clr,
   // Timer configuration
   input  wire logic        i_timer_clear_on_capture,
   input  wire logic        i_compare_not_reload,
   input  wire logic        i_reload_enable,
   input  wire logic [1:0]  i_capture_reload_select,
   input  wire logic        i_timer_irq_enable,
   input  wire logic [15:0] i_timer_match_reload,
   input  wire logic        i_timer_match_flag_clr,
   // Encoder configuration
   input  wire logic        i_encoder_enable,
   input  wire logic        i_index_capture_disable,
   input  wire logic [1:0]  i_encoder_mode_select,
   input  wire logic        i_pulse_limit_wr,
   input  wire logic [15:0] i_pulse_limit_data,
   input  wire logic        i_pulse_counter_wr,
   input  wire logic [15:0] i_pulse_counter_data,
   input  wire logic        i_pulse_latch_load,
   // Register pairs
   output logic [15:0]      o_reg_pair_0,
   output logic [15:0]      o_reg_pair_1,
   output logic [15:0]      o_reg_pair_2,
   // Status and requests
   output logic [2:0]       o_capture_flag,
   output logic             o_capture_irq,
   output logic [15:0]      o_timer_count,
   output logic             o_timer_match_flag,
   output logic             o_timer_irq,
   output logic             o_rotation_sense
);
   logic        enc_en_r;
   logic [15:0] tmr_r;
   logic [15:0] tmr_nxt;
   logic [15:0] cap_r [NCH];
   logic [2:0]  flag_r;
   logic [2:0]  flag_set;
   logic        tmatch_r;
   logic        tmatch_set;
   logic [2:0]  edge_hit;
   logic [2:0]  cap_trig;
   logic        any_trig;
   logic        rld_trig;
   logic [15:0] pulse_read_latch_r;
   logic [15:0] pulse_read_latch_nxt;
   logic [15:0] plim_r;
   logic [15:0] plat_r;
   logic        sense_r;
   logic        a_edge;
   logic        b_edge;
   logic        cnt_evt;
   logic        cnt_up;
   logic        wrap;
   logic        x4_mode;
   logic        cmp_mode;

   mfb_edge_if ch_if [NCH] ();

   for (genvar g = 0; g < NCH; g++) begin : g_chan
      mfb_edge_filter #(
         .FILT_LEN    (mfb_pkg::FILTER_LEN)
      ) u_filt (
         .i_core_clk  (i_core_clk),
         .i_sys_rst   (i_sys_rst),
         .i_pin       (i_capture_pin[g]),
         .i_filter_en (i_filter_enable[g]),
         .o_edge      (ch_if[g])
      );

      always_comb begin
         case (i_edge_select[2*g +: 2])
            mfb_pkg::EDGE_RISE: edge_hit[g] = ch_if[g].rise; // R4
            mfb_pkg::EDGE_FALL: edge_hit[g] = ch_if[g].fall; // R4
            mfb_pkg::EDGE_BOTH:
               edge_hit[g] = ch_if[g].rise | ch_if[g].fall;   // R4
            default:            edge_hit[g] = 1'b0;
         endcase
      end
   end

   // Encoder selection is captured so reset always starts in capture
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         enc_en_r <= 1'b0; // R1
      end else begin
         enc_en_r <= i_encoder_enable;
      end
   end

   // Pins 0 and 1 belong to the encoder while it is selected
   assign cap_trig[0] = edge_hit[0] & i_capture_enable[0] & ~enc_en_r; // R1
   assign cap_trig[1] = edge_hit[1] & i_capture_enable[1] & ~enc_en_r; // R1
   assign cap_trig[2] = edge_hit[2] & i_capture_enable[2]
                        & (~enc_en_r | ~i_index_capture_disable); // R12
   assign any_trig    = |cap_trig;
   assign rld_trig    = i_capture_reload_select != mfb_pkg::RLD_NONE
                        && cap_trig[i_capture_reload_select - 2'h1]; // R11

   // Capture stores take the timer value seen before any clear
   for (genvar g = 0; g < NCH; g++) begin : g_cap
      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            cap_r[g] <= mfb_pkg::TIMER_RST;
         end else if (cap_trig[g] && !enc_en_r) begin
            cap_r[g] <= tmr_r; // R5
         end
      end
   end

   // Timer next value, capture clear has highest priority
   always_comb begin
      tmr_nxt    = tmr_r + 16'h0001;
      tmatch_set = 1'b0;
      if (any_trig && i_timer_clear_on_capture) begin
         tmr_nxt = mfb_pkg::TIMER_RST; // R7
      end else if (rld_trig) begin
         tmr_nxt = i_timer_match_reload; // R11
      end else if (i_compare_not_reload) begin
         if (tmr_r == i_timer_match_reload) begin
            tmr_nxt    = mfb_pkg::TIMER_RST; // R9
            tmatch_set = 1'b1;               // R9
         end
      end else if (tmr_r == mfb_pkg::COUNT_MAX) begin
         tmatch_set = 1'b1; // R10
         if (i_reload_enable && !i_timer_clear_on_capture) begin
            tmr_nxt = i_timer_match_reload; // R8
         end else begin
            tmr_nxt = mfb_pkg::TIMER_RST; // R8 R10
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tmr_r <= mfb_pkg::TIMER_RST;
      end else begin
         tmr_r <= tmr_nxt;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tmatch_r <= 1'b0;
      end else begin
         tmatch_r <= (tmatch_r & ~i_timer_match_flag_clr) | tmatch_set;
      end
   end

   // Encoder decoding on filtered phase inputs
   assign x4_mode  = ~i_encoder_mode_select[mfb_pkg::MODE_X2_BIT]; // R13 R23
   assign cmp_mode = i_encoder_mode_select[mfb_pkg::MODE_CMP_BIT]; // R13
   assign a_edge   = ch_if[0].rise | ch_if[0].fall; // R16
   assign b_edge   = ch_if[1].rise | ch_if[1].fall; // R16
   // Simultaneous edges on both phases are invalid; phase A wins
   assign cnt_evt  = enc_en_r & (a_edge | (x4_mode & b_edge)); // R17 R23
   assign cnt_up   = a_edge ? (ch_if[0].level ^ ch_if[1].level)
                            : ~(ch_if[0].level ^ ch_if[1].level); // R24

   always_comb begin
      pulse_read_latch_nxt = pulse_read_latch_r;
      wrap     = 1'b0;
      if (cnt_evt) begin
         if (cnt_up) begin
            if (cmp_mode && pulse_read_latch_r == plim_r) begin
               pulse_read_latch_nxt = mfb_pkg::COUNT_RST; // R18 R25
               wrap     = 1'b1;               // R25
            end else if (!cmp_mode && pulse_read_latch_r == mfb_pkg::COUNT_MAX) begin
               pulse_read_latch_nxt = mfb_pkg::COUNT_RST; // R18
               wrap     = 1'b1;               // R21
            end else begin
               pulse_read_latch_nxt = pulse_read_latch_r + 16'h0001; // R24
            end
         end else if (pulse_read_latch_r == mfb_pkg::COUNT_RST) begin
            pulse_read_latch_nxt = cmp_mode ? plim_r : mfb_pkg::COUNT_MAX; // R26
            wrap     = 1'b1;                                   // R21 R26
         end else begin
            pulse_read_latch_nxt = pulse_read_latch_r - 16'h0001; // R24
         end
      end else if (i_pulse_counter_wr) begin
         pulse_read_latch_nxt = i_pulse_counter_data;
      end
   end

   // Counter only moves on events or writes, never on mode changes
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pulse_read_latch_r <= mfb_pkg::COUNT_RST;
      end else begin
         pulse_read_latch_r <= pulse_read_latch_nxt; // R14 R19
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         plim_r <= mfb_pkg::COUNT_RST;
      end else if (i_pulse_limit_wr) begin
         plim_r <= i_pulse_limit_data;
      end
   end

   // Latched copy gives software a coherent 16-bit read
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         plat_r <= mfb_pkg::COUNT_RST;
      end else if (i_pulse_latch_load) begin
         plat_r <= pulse_read_latch_r; // R14
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sense_r <= 1'b0;
      end else if (cnt_evt) begin
         sense_r <= cnt_up; // R17 R24
      end
   end

   // Flag sources depend on which sub-module owns the pins
   always_comb begin
      if (enc_en_r) begin
         flag_set[0] = wrap;                           // R21 R22
         flag_set[1] = cnt_evt & (cnt_up != sense_r);  // R22 R27
         flag_set[2] = cap_trig[2];                    // R20
      end else begin
         flag_set = cap_trig; // R5
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_r <= 3'h0;
      end else begin
         flag_r <= (flag_r & ~i_capture_flag_clr) | flag_set; // R6
      end
   end

   // Outputs registered; pair views trail internal state by one cycle
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_reg_pair_0       <= mfb_pkg::TIMER_RST;
         o_reg_pair_1       <= mfb_pkg::TIMER_RST;
         o_reg_pair_2       <= mfb_pkg::TIMER_RST;
         o_capture_flag     <= 3'h0;
         o_capture_irq      <= 1'b0;
         o_timer_count      <= mfb_pkg::TIMER_RST;
         o_timer_match_flag <= 1'b0;
         o_timer_irq        <= 1'b0;
         o_rotation_sense   <= 1'b0;
      end else begin
         o_reg_pair_0       <= enc_en_r ? plat_r : cap_r[0]; // R15
         o_reg_pair_1       <= enc_en_r ? pulse_read_latch_r : cap_r[1]; // R15
         o_reg_pair_2       <= enc_en_r ? plim_r : cap_r[2]; // R15
         o_capture_flag     <= flag_r;
         o_capture_irq      <= (|flag_r) & i_capture_irq_enable; // R6
         o_timer_count      <= tmr_r;
         o_timer_match_flag <= tmatch_r;
         o_timer_irq        <= tmatch_r & i_timer_irq_enable; // R9 R10
         o_rotation_sense   <= sense_r;
      end
   end

   chk_pins_owned_once: assert property ( // R1
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !((cap_trig[0] || cap_trig[1]) && cnt_evt))
      else $error("capture and encoder both used shared pins");

   chk_capture_copies_timer: assert property ( // R5
      @(posedge i_core_clk) disable iff (i_sys_rst)
      cap_trig[0] |=> (cap_r[0] == $past(tmr_r) && flag_r[0]))
      else $error("capture did not copy timer or set flag");

   chk_flag_set_wins: assert property ( // R6
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (flag_set[1] && i_capture_flag_clr[1]) |=> flag_r[1])
      else $error("flag set lost against clear");

   chk_flag_stays_set: assert property ( // R6
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (flag_r[2] && !i_capture_flag_clr[2]) |=> flag_r[2])
      else $error("capture flag cleared without software");

   chk_clear_after_capture: assert property ( // R7
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (any_trig && i_timer_clear_on_capture) |=> tmr_r == 16'h0000)
      else $error("timer not cleared after capture");

   chk_reload_on_overflow: assert property ( // R8
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!any_trig && !i_compare_not_reload && i_reload_enable
       && !i_timer_clear_on_capture && tmr_r == 16'hffff)
      |=> (tmr_r == $past(i_timer_match_reload) && tmatch_r))
      else $error("overflow did not load reload value");

   chk_compare_restart: assert property ( // R9
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!any_trig && i_compare_not_reload
       && tmr_r == i_timer_match_reload)
      |=> (tmr_r == 16'h0000 && tmatch_r) ##1 tmr_r == 16'h0001)
      else $error("compare match did not restart timer");

   chk_index_gating: assert property ( // R12
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (enc_en_r && i_index_capture_disable) |-> !cap_trig[2])
      else $error("index capture while disabled");

   chk_free_wrap: assert property ( // R21
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (cnt_evt && cnt_up && !cmp_mode && pulse_read_latch_r == 16'hffff)
      |=> (pulse_read_latch_r == 16'h0000 && flag_r[0]))
      else $error("free counter wrap missing");

   chk_counter_held: assert property ( // R19
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (!enc_en_r && !i_pulse_counter_wr) |=> $stable(pulse_read_latch_r))
      else $error("pulse counter moved while encoder off");

   chk_compare_down: assert property ( // R26
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (cnt_evt && !cnt_up && cmp_mode && pulse_read_latch_r == 16'h0000)
      |=> (pulse_read_latch_r == $past(plim_r) && flag_r[0]))
      else $error("compare underflow did not reload limit");
endmodule : mfb_motion_feedback

/* sim/mfb_pulse_src.sv */
/*
 Far side of the motion feedback block: a quadrature encoder on pins
 0 and 1 and a pulse source on any capture pin.
 Assumes the bench calls its tasks; pins change at falling edges.
*/
`timescale 1ns/100ps
module mfb_pulse_src (
   // Clock
   input  wire logic  i_core_clk,
   // Pins
   output logic [2:0] o_pin
);
   int phase;

   initial begin
      o_pin = 3'h0;
      phase = 0;
   end

   // Drive one pin and hold it n cycles; narrow only when asked
   task automatic level(input int ch, input logic v, input int n);
      @(negedge i_core_clk);
      o_pin[ch] = v;
      repeat (n - 1) @(negedge i_core_clk);
   endtask : level

   // One quadrature step; phase A leads B when dir is 1
   task automatic step(input int dir);
      phase = (phase + (dir != 0 ? 1 : 3)) % 4;
      @(negedge i_core_clk);
      o_pin[0] = (phase == 1) || (phase == 2);
      o_pin[1] = (phase >= 2);
      repeat (8) @(negedge i_core_clk);
   endtask : step
endmodule : mfb_pulse_src

/* sim/test_mfb_motion_feedback.sv */
/*
 Self-checking bench of the motion feedback block: capture, filter,
 encoder and timer scenarios. Assumes the pulse source model.
*/
`timescale 1ns/100ps
module test_mfb_motion_feedback;
   typedef struct {int s; logic [15:0] v; logic [15:0] m;} mfb_note_type;
   logic        i_core_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   wire logic [2:0] i_capture_pin;
   logic [2:0]  i_filter_enable = 3'h0;
   logic [5:0]  i_edge_select = 6'h3f;
   logic [2:0]  i_capture_enable = 3'h7;
   logic        i_capture_irq_enable = 1'b1;
   logic [2:0]  i_capture_flag_clr = 3'h0;
   logic        i_timer_clear_on_capture = 1'b1;
   logic        i_compare_not_reload = 1'b0;
   logic        i_reload_enable = 1'b0;
   logic [1:0]  i_capture_reload_select = 2'h0;
   logic        i_timer_irq_enable = 1'b1;
   logic [15:0] i_timer_match_reload = 16'h0000;
   logic        i_timer_match_flag_clr = 1'b0;
   logic        i_encoder_enable = 1'b0;
   logic        i_index_capture_disable = 1'b0;
   logic [1:0]  i_encoder_mode_select = 2'h0;
   logic        i_pulse_limit_wr = 1'b0;
   logic [15:0] i_pulse_limit_data = 16'h0000;
   logic        i_pulse_counter_wr = 1'b0;
   logic [15:0] i_pulse_counter_data = 16'h0000;
   logic        i_pulse_latch_load = 1'b0;
   logic [15:0] o_reg_pair_0, o_reg_pair_1, o_reg_pair_2, o_timer_count;
   logic [2:0]  o_capture_flag;
   logic        o_capture_irq, o_timer_match_flag, o_timer_irq;
   logic        o_rotation_sense;
   mfb_note_type q [$];
   mfb_note_type nt;
   int          n_mismatch = 0, checks = 0, cyc = 0, w, c;

   always #50 i_core_clk = ~i_core_clk;

   mfb_motion_feedback u_mfb_motion_feedback (
      .i_core_clk, .i_sys_rst, .i_capture_pin, .i_filter_enable,
      .i_edge_select, .i_capture_enable, .i_capture_irq_enable,
      .i_capture_flag_clr, .i_timer_clear_on_capture,
      .i_compare_not_reload, .i_reload_enable, .i_capture_reload_select,
      .i_timer_irq_enable, .i_timer_match_reload, .i_timer_match_flag_clr,
      .i_encoder_enable, .i_index_capture_disable, .i_encoder_mode_select,
      .i_pulse_limit_wr, .i_pulse_limit_data, .i_pulse_counter_wr,
      .i_pulse_counter_data, .i_pulse_latch_load, .o_reg_pair_0,
      .o_reg_pair_1, .o_reg_pair_2, .o_capture_flag, .o_capture_irq,
      .o_timer_count, .o_timer_match_flag, .o_timer_irq, .o_rotation_sense
   );

   mfb_pulse_src u_mfb_pulse_src (.i_core_clk, .o_pin(i_capture_pin));

   // Status word: flags, capture irq, timer flag, timer irq, sense
   function automatic logic [15:0] seen(input int s);
      case (s)
         0: return o_reg_pair_0;
         1: return o_reg_pair_1;
         2: return o_reg_pair_2;
         3: return {9'h0, o_rotation_sense, o_timer_irq,
                    o_timer_match_flag, o_capture_irq, o_capture_flag};
         default: return o_timer_count;
      endcase
   endfunction : seen

   task automatic cmp_word(input string n, input logic [15:0] e, a);
      checks++;
      if (a !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, a);
      end
   endtask : cmp_word

   task automatic cmp_bits(input string n, input logic [15:0] e, a, m);
      checks++;
      if ((a & m) !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, a & m);
      end
   endtask : cmp_bits

   task automatic want(input int s, input logic [15:0] v, m);
      q.push_back('{s, v, m});
   endtask : want

   // One-cycle strobes; data ports share the value
   task automatic cmd(input int k, input logic [15:0] d);
      @(negedge i_core_clk);
      case (k)
         0: i_capture_flag_clr = d[2:0];
         1: i_pulse_counter_wr = 1'b1;
         2: i_pulse_limit_wr = 1'b1;
         3: i_pulse_latch_load = 1'b1;
         default: i_timer_match_flag_clr = 1'b1;
      endcase
      i_pulse_counter_data = d;
      i_pulse_limit_data = d;
      @(negedge i_core_clk);
      {i_capture_flag_clr, i_pulse_counter_wr, i_pulse_limit_wr} = 5'h00;
      {i_pulse_latch_load, i_timer_match_flag_clr} = 2'h0;
      repeat (3) @(negedge i_core_clk);
   endtask : cmd

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   always begin
      wait (q.size() != 0);
      nt = q.pop_front();
      if (nt.s < 3)
         cmp_word($sformatf("pair%0d", nt.s), nt.v, seen(nt.s));
      else
         cmp_bits($sformatf("status%0d", nt.s), nt.v, seen(nt.s), nt.m);
   end

   // Cut a hang short well beyond the expected run length
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      w = $urandom(80);
      repeat (2) @(negedge i_core_clk);
      i_sys_rst = 1'b0;
      for (c = 0; c < 3; c++) begin
         w = 5 + $urandom % 20;
         u_mfb_pulse_src.level(c, 1'b1, w);
         u_mfb_pulse_src.level(c, 1'b0, 8);
         want(c, 16'(w - 1), 16'hffff);
         want(3, 16'h8 | 16'(1 << c), 16'hf);
         i_capture_irq_enable = 1'b0;
         repeat (2) @(negedge i_core_clk);
         want(3, 16'(1 << c), 16'hf);
         i_capture_irq_enable = 1'b1;
         cmd(0, 16'h7);
         want(3, 16'h0, 16'hf);
         i_capture_enable[c] = 1'b0;
         u_mfb_pulse_src.level(c, 1'b1, 8);
         u_mfb_pulse_src.level(c, 1'b0, 8);
         want(c, 16'(w - 1), 16'hffff);
         want(3, 16'h0, 16'hf);
         i_capture_enable[c] = 1'b1;
      end
      $display("test capture done");
      for (c = 0; c < 4; c++) begin
         i_edge_select[3:2] = 2'(c);
         cmd(0, 16'h7);
         u_mfb_pulse_src.level(1, 1'b1, 8);
         want(3, 16'(c % 2) << 1, 16'h2);
         u_mfb_pulse_src.level(1, 1'b0, 8);
         want(3, 16'(c != 0) << 1, 16'h2);
      end
      i_edge_select = 6'h3f;
      i_filter_enable = 3'h7;
      cmd(0, 16'h7);
      u_mfb_pulse_src.level(2, 1'b1, 3);
      u_mfb_pulse_src.level(2, 1'b0, 8);
      want(3, 16'h0, 16'h4);
      u_mfb_pulse_src.level(2, 1'b1, 4);
      u_mfb_pulse_src.level(2, 1'b0, 8);
      want(3, 16'h4, 16'h4);
      i_filter_enable = 3'h0;
      $display("test edges done");
      i_encoder_enable = 1'b1;
      cmd(1, 16'hfffe);
      u_mfb_pulse_src.step(1);
      u_mfb_pulse_src.step(1);
      want(1, 16'h0000, 16'hffff);
      want(3, 16'h41, 16'h41);
      cmd(0, 16'h7);
      u_mfb_pulse_src.step(0);
      want(1, 16'hffff, 16'hffff);
      want(3, 16'h03, 16'h43);
      i_encoder_mode_select = 2'h1;
      repeat (3) @(negedge i_core_clk);
      want(1, 16'hffff, 16'hffff);
      repeat (4) u_mfb_pulse_src.step(0);
      want(1, 16'hfffd, 16'hffff);
      i_encoder_mode_select = 2'h2;
      cmd(2, 16'h0003);
      cmd(1, 16'h0002);
      want(2, 16'h0003, 16'hffff);
      u_mfb_pulse_src.step(1);
      cmd(0, 16'h7);
      u_mfb_pulse_src.step(1);
      want(1, 16'h0000, 16'hffff);
      want(3, 16'h01, 16'h01);
      cmd(0, 16'h7);
      u_mfb_pulse_src.step(0);
      want(1, 16'h0003, 16'hffff);
      want(3, 16'h01, 16'h01);
      cmd(3, 16'h0000);
      want(0, 16'h0003, 16'hffff);
      for (c = 1; c >= 0; c--) begin
         i_index_capture_disable = c[0];
         cmd(0, 16'h7);
         u_mfb_pulse_src.level(2, c[0], 8);
         want(3, 16'(1 - c) << 2, 16'h4);
      end
      $display("test encoder done");
      i_encoder_enable = 1'b0;
      i_timer_clear_on_capture = 1'b0;
      i_reload_enable = 1'b1;
      i_capture_reload_select = 2'h1;
      i_timer_match_reload = 16'hfff0;
      u_mfb_pulse_src.level(0, 1'b0, 8);
      u_mfb_pulse_src.level(1, 1'b0, 8);
      cmd(0, 16'h7);
      cmd(4, 16'h0000);
      u_mfb_pulse_src.level(0, 1'b1, 30);
      u_mfb_pulse_src.level(0, 1'b0, 8);
      want(0, 16'hfffd, 16'hffff);
      want(3, 16'h31, 16'h31);
      i_timer_irq_enable = 1'b0;
      repeat (2) @(negedge i_core_clk);
      want(3, 16'h10, 16'h30);
      i_timer_irq_enable = 1'b1;
      $display("test reload done");
      i_compare_not_reload = 1'b1;
      i_timer_clear_on_capture = 1'b1;
      i_timer_match_reload = 16'h0009;
      u_mfb_pulse_src.level(0, 1'b1, 8);
      cmd(4, 16'h0000);
      repeat (12) begin
         @(negedge i_core_clk);
         want(4, 16'h0000, 16'hfff0);
      end
      want(3, 16'h30, 16'h30);
      $display("test compare done");
      wait (q.size() == 0);
      report_and_stop();
   end
endmodule : test_mfb_motion_feedback
